// ---- rtl/rps_map.svh ----
// offsets, field positions, reset values and cycle counts of the reset pin sequencer
`ifndef RPS_MAP_SVH
`define RPS_MAP_SVH

// ----------------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define RPS_OFS_INTERRUPT_CONTROL 12'h000
`define RPS_OFS_PULLUP_CONTROL    12'h004
`define RPS_OFS_CONDITION_CODE    12'h008
`define RPS_OFS_SEQ_CONTROL       12'h00C
`define RPS_OFS_STATUS            12'h010

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define RPS_ICR_EDGE_SEL    0
`define RPS_ICR_IRQ_ENABLE  1
`define RPS_PUC_PU_EN       0
`define RPS_CC_I_MASK       0
`define RPS_CC_X_MASK       1
`define RPS_SEQ_WD_ENABLE   0
`define RPS_SEQ_CM_ENABLE   1

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define RPS_RST_ICR 2'h2
`define RPS_RST_PUC 1'h1
`define RPS_RST_CC  2'h3
`define RPS_RST_SEQ 2'h0

// ----------------------------------------------------------------------------
// vectors and cycle counts
// ----------------------------------------------------------------------------
`define RPS_VEC_NORMAL   16'hFFFE
`define RPS_VEC_CLKMON   16'hFFFC
`define RPS_VEC_WATCHDOG 16'hFFFA
`define RPS_OSC_CYCLES    4096
`define RPS_DRIVE_CYCLES  16
`define RPS_SAMPLE_CYCLES 9
`define RPS_CNT_W         13

`endif

// ---- rtl/rps_pkg.sv ----
// types shared by the reset pin sequencer files
package rps_pkg;

   // sequencer states
   typedef enum logic [2:0]
   {
      st_run     = 3'b000,
      st_osc     = 3'b001,
      st_drive   = 3'b010,
      st_release = 3'b011,
      st_hold    = 3'b100
   } rps_state_type;

endpackage

// ---- rtl/rps_cnt_if.sv ----
// link between the sequencer and its phase counter
`timescale 1ns/1ns
`include "rps_map.svh"

interface rps_cnt_if;
   logic                   restart;   // phase begins next cycle
   logic [`RPS_CNT_W-1:0]  limit;     // cycles in this phase
   logic                   hit;       // last cycle of the phase

   modport seq (output restart, output limit, input hit);
   modport cnt (input restart, input limit, output hit);
endinterface

// ---- rtl/rps_phase_cnt.sv ----
// phase counter: flags the last cycle of a phase of programmable length
`timescale 1ns/1ns
`include "rps_map.svh"

module rps_phase_cnt
(
   input  wire logic  pclk,
   input  wire logic  presetn,
   rps_cnt_if.cnt     cif
);
   import rps_pkg::*;

   logic [`RPS_CNT_W-1:0] count;
   logic [`RPS_CNT_W-1:0] next_count;

   // --------------------------------------------------------------------------
   // counting
   // --------------------------------------------------------------------------

   // restart clears, otherwise count up
   always_comb
   begin
      if (cif.restart)
      begin
         next_count = '0;
      end
      else
      begin
         next_count = count + `RPS_CNT_W'(1);
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         count <= '0;
      end
      else
      begin
         count <= next_count;
      end
   end

   // last cycle of the phase
   assign cif.hit = (count == cif.limit - `RPS_CNT_W'(1));

endmodule

// ---- rtl/rps_sequencer.sv ----
// reset pin sequencer with interrupt pin control and apb registers
// Operation
// R1: four causes start the reset sequence
// R2: async reset entry, synchronous release
// R3: open-drain low drive on any cause
// R4: power-on/clock-fail wait 4096 cycles first
// R5: drive pin low 16 cycles, then release
// R6: sample pin nine cycles after release
// R7: pin low: clear flags, normal vector
// R8: pin high, clock fail: clock-monitor vector
// R9: pin high, watchdog only: watchdog vector
// R10: pin high, no flags: normal vector
// R11: outside pin rises within nine cycles
// R12: edge/level select, enabled level at reset
// R13: clearing enable disables maskable pin
// R14: reset sets maskable interrupt mask
// R15: reset sets nonmaskable interrupt mask
// R16: pins readable, pull-ups, pull-up enable bit
// R17: nonmaskable input is level sensitive
// R18: shared sources open-drain, held until acknowledged
// R19: held line re-requests once mask clears
// R20: latch mode pins, pull-downs in reset
// R21: present chosen vector at reset release
//
// Design decisions made here: the register offsets and the APB slave port.
`timescale 1ns/1ns
`include "rps_map.svh"

module rps_sequencer
#(
   parameter int OSC_CYCLES    = `RPS_OSC_CYCLES,
   parameter int DRIVE_CYCLES  = `RPS_DRIVE_CYCLES,
   parameter int SAMPLE_CYCLES = `RPS_SAMPLE_CYCLES
)
(
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic         psel,
   input  wire logic         penable,
   input  wire logic         pwrite,
   input  wire logic [11:0]  paddr,
   input  wire logic [31:0]  pwdata,
   output logic      [31:0]  prdata,
   output logic              pready,
   output logic              pslverr,
   input  wire logic         reset_pin_in,
   output logic              reset_pin_out,
   output logic              reset_pin_oe,
   input  wire logic         watchdog_timer_timeout,
   input  wire logic         clock_fail,
   input  wire logic         maskable_irq_pin,
   input  wire logic         nonmaskable_irq_pin,
   input  wire logic         maskable_irq_ack,
   output logic              irq_pullup_en,
   output logic              maskable_irq_req,
   output logic              nonmaskable_irq_req,
   input  wire logic         mode_select_lo,
   input  wire logic         mode_select_hi,
   input  wire logic         special_mode_pin,
   output logic              mode_pulldown_en,
   output logic      [2:0]   op_mode,
   output logic              core_reset_n,
   output logic      [15:0]  reset_vector
);
   import rps_pkg::*;

   // --------------------------------------------------------------------------
   // state
   // --------------------------------------------------------------------------
   rps_state_type state;
   rps_state_type next_state;
   logic          wd_flag;
   logic          next_wd_flag;
   logic          cm_flag;
   logic          next_cm_flag;
   logic [15:0]   next_reset_vector;
   logic [2:0]    next_op_mode;
   logic [1:0]    icr;
   logic [1:0]    next_icr;
   logic          pu_bit;
   logic          next_pu_bit;
   logic [1:0]    cc_reg;
   logic [1:0]    next_cc_reg;
   logic [1:0]    seq_ctrl;
   logic [1:0]    next_seq_ctrl;
   logic          irq_prev;
   logic          edge_pend;
   logic          next_edge_pend;
   logic [31:0]   next_prdata;
   logic          in_reset;
   logic          wd_event;
   logic          cm_event;
   logic          wr_en;
   logic          sample;

   rps_cnt_if cif ();

   // phase counter
   rps_phase_cnt u_cnt
   (
      .pclk    (pclk),
      .presetn (presetn),
      .cif     (cif)
   );

   // address decode used by the error path (pslverr) only
   function automatic logic rps_mapped(input logic [11:0] a);
      rps_mapped = (a == `RPS_OFS_INTERRUPT_CONTROL) || (a == `RPS_OFS_PULLUP_CONTROL)
                || (a == `RPS_OFS_CONDITION_CODE) || (a == `RPS_OFS_SEQ_CONTROL)
                || (a == `RPS_OFS_STATUS);
   endfunction

   // --------------------------------------------------------------------------
   // reset causes and pin drive
   // --------------------------------------------------------------------------

   // faults only count while their monitor is enabled
   assign wd_event = watchdog_timer_timeout && seq_ctrl[`RPS_SEQ_WD_ENABLE];   // see R1
   assign cm_event = clock_fail && seq_ctrl[`RPS_SEQ_CM_ENABLE];               // see R1
   assign in_reset = (state != st_run);

   // open-drain: never drives high
   assign reset_pin_out = 1'b0;
   assign reset_pin_oe  = (state == st_osc) || (state == st_drive);            // see R3

   // entry is combinational so a dead clock still resets the core
   assign core_reset_n = presetn && !in_reset && reset_pin_in && !wd_event
                         && !cm_event;                                         // see R2
   assign sample = (state == st_release) && cif.hit;
   assign cif.restart = (next_state != state);

   // phase lengths
   always_comb
   begin
      case (state)
         st_osc:     cif.limit = `RPS_CNT_W'(OSC_CYCLES);                      // see R4
         st_drive:   cif.limit = `RPS_CNT_W'(DRIVE_CYCLES);                    // see R5
         st_release: cif.limit = `RPS_CNT_W'(SAMPLE_CYCLES);                   // see R6
         default:    cif.limit = `RPS_CNT_W'(1);
      endcase
   end

   // --------------------------------------------------------------------------
   // sequencer
   // --------------------------------------------------------------------------

   // walks the recovery phases and chooses the vector
   always_comb
   begin
      next_state        = state;
      next_reset_vector = reset_vector;
      // set wins over the clear at the sampling point
      next_wd_flag      = wd_flag || wd_event;
      next_cm_flag      = cm_flag || cm_event;
      case (state)
         st_run:
         begin
            if (cm_event)
            begin
               next_state = st_osc;                                            // see R4
            end
            else if (wd_event || !reset_pin_in)
            begin
               next_state = st_drive;                                          // see R1
            end
         end
         st_osc:
         begin
            if (cif.hit)
            begin
               next_state = st_drive;
            end
         end
         st_drive:
         begin
            if (cif.hit)
            begin
               next_state = st_release;                                        // see R5
            end
         end
         st_release:
         begin
            if (cif.hit)
            begin
               if (!reset_pin_in)
               begin
                  next_state        = st_hold;
                  next_reset_vector = `RPS_VEC_NORMAL;                         // see R7
                  next_wd_flag      = wd_event;
                  next_cm_flag      = cm_event;
               end
               else
               begin
                  next_state   = st_run;                                       // see R11
                  // latched causes are used up by this vector choice
                  next_wd_flag = wd_event;
                  next_cm_flag = cm_event;
                  if (cm_flag)
                  begin
                     next_reset_vector = `RPS_VEC_CLKMON;                      // see R8
                  end
                  else if (wd_flag)
                  begin
                     next_reset_vector = `RPS_VEC_WATCHDOG;                    // see R9
                  end
                  else
                  begin
                     next_reset_vector = `RPS_VEC_NORMAL;                      // see R10
                  end
               end
            end
         end
         st_hold:
         begin
            // outside request still holds the pin; release when it lets go
            if (reset_pin_in)
            begin
               next_state = st_run;                                            // see R2
            end
         end
         default:
         begin
            next_state = st_osc;
         end
      endcase
   end

   // power-on enters the oscillator wait
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state        <= st_osc;                                               // see R4
         wd_flag      <= 1'b0;
         cm_flag      <= 1'b0;
         reset_vector <= `RPS_VEC_NORMAL;
      end
      else
      begin
         state        <= next_state;
         wd_flag      <= next_wd_flag;
         cm_flag      <= next_cm_flag;
         reset_vector <= next_reset_vector;                                    // see R21
      end
   end

   // --------------------------------------------------------------------------
   // mode pins and pull controls
   // --------------------------------------------------------------------------

   // mode follows the pins only while in reset
   assign next_op_mode     = in_reset ? {special_mode_pin, mode_select_hi, mode_select_lo}
                                      : op_mode;                               // see R20
   assign mode_pulldown_en = in_reset;                                         // see R20
   assign irq_pullup_en    = in_reset || pu_bit;                               // see R16

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         op_mode <= 3'h0;
      end
      else
      begin
         op_mode <= next_op_mode;
      end
   end

   // --------------------------------------------------------------------------
   // interrupt pins
   // --------------------------------------------------------------------------

   // falling edge pending; a new edge beats the acknowledge
   assign next_edge_pend = in_reset ? 1'b0 :
                           ((edge_pend && !maskable_irq_ack)
                           || (irq_prev && !maskable_irq_pin && icr[`RPS_ICR_EDGE_SEL]));

   // level or edge request, gated by enable and mask
   assign maskable_irq_req = !in_reset && icr[`RPS_ICR_IRQ_ENABLE]             // see R13
                             && !cc_reg[`RPS_CC_I_MASK]                        // see R19
                             && (icr[`RPS_ICR_EDGE_SEL] ? edge_pend
                                                        : !maskable_irq_pin);  // see R12
   // level only, so a wired-or line keeps asking while held low
   assign nonmaskable_irq_req = !in_reset && !cc_reg[`RPS_CC_X_MASK]
                                && !nonmaskable_irq_pin;                       // see R17

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irq_prev  <= 1'b1;
         edge_pend <= 1'b0;
      end
      else
      begin
         irq_prev  <= maskable_irq_pin;
         edge_pend <= next_edge_pend;
      end
   end

   // --------------------------------------------------------------------------
   // apb registers
   // --------------------------------------------------------------------------
   assign wr_en   = psel && penable && pwrite;
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !rps_mapped(paddr);

   // writes at the access phase; any reset restores defaults except seq_ctrl, which only presetn resets
   always_comb
   begin
      next_icr      = icr;
      next_pu_bit   = pu_bit;
      next_cc_reg   = cc_reg;
      next_seq_ctrl = seq_ctrl;
      if (in_reset)
      begin
         next_icr      = `RPS_RST_ICR;                                         // see R12
         next_pu_bit   = `RPS_RST_PUC;                                         // see R16
         next_cc_reg   = `RPS_RST_CC;                                          // see R14 R15
         next_seq_ctrl = seq_ctrl;
      end
      else if (wr_en)
      begin
         case (paddr)
            `RPS_OFS_INTERRUPT_CONTROL: next_icr = pwdata[1:0];                // see R13
            `RPS_OFS_PULLUP_CONTROL:    next_pu_bit = pwdata[`RPS_PUC_PU_EN];  // see R16
            `RPS_OFS_CONDITION_CODE:
            begin
               next_cc_reg[`RPS_CC_I_MASK] = pwdata[`RPS_CC_I_MASK];
               // the nonmaskable mask can only be cleared by software
               next_cc_reg[`RPS_CC_X_MASK] = cc_reg[`RPS_CC_X_MASK]
                                             && pwdata[`RPS_CC_X_MASK];        // see R15
            end
            `RPS_OFS_SEQ_CONTROL:       next_seq_ctrl = pwdata[1:0];
            default:                    next_icr = icr;
         endcase
      end
   end

   // read data captured in the setup phase
   always_comb
   begin
      next_prdata = prdata;
      if (psel && !penable)
      begin
         case (paddr)
            `RPS_OFS_INTERRUPT_CONTROL: next_prdata = {30'h0, icr};
            `RPS_OFS_PULLUP_CONTROL:    next_prdata = {31'h0, pu_bit};
            `RPS_OFS_CONDITION_CODE:    next_prdata = {30'h0, cc_reg};
            `RPS_OFS_SEQ_CONTROL:       next_prdata = {30'h0, seq_ctrl};
            `RPS_OFS_STATUS:            next_prdata = {reset_vector, 8'h0, op_mode,
                                           edge_pend, nonmaskable_irq_pin,
                                           maskable_irq_pin, cm_flag, wd_flag};  // see R16
            default:                    next_prdata = 32'h0;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         icr      <= `RPS_RST_ICR;
         pu_bit   <= `RPS_RST_PUC;
         cc_reg   <= `RPS_RST_CC;
         seq_ctrl <= `RPS_RST_SEQ;
         prdata   <= 32'h0;
      end
      else
      begin
         icr      <= next_icr;
         pu_bit   <= next_pu_bit;
         cc_reg   <= next_cc_reg;
         seq_ctrl <= next_seq_ctrl;
         prdata   <= next_prdata;
      end
   end

   // --------------------------------------------------------------------------
   // assertions
   // --------------------------------------------------------------------------
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   logic        in_osc;
   logic        in_drive;
   logic        in_rel;
   logic [12:0] osc_len;

   assign in_osc   = (state == st_osc);
   assign in_drive = (state == st_drive);
   assign in_rel   = (state == st_release);

   // length of the current oscillator wait
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         osc_len <= 13'h0000;
      end
      else
      begin
         osc_len <= in_osc ? osc_len + 13'h0001 : 13'h0000;
      end
   end

   sequence s_drive_phase;
      (in_drive && reset_pin_oe)[*8] ##1 (in_drive && reset_pin_oe)[*8];
   endsequence

   a_drive_low_len: assert property ($rose(in_drive) |-> s_drive_phase ##1 in_rel)  // see R5
      else $error("low drive did not last sixteen cycles");
   a_sample_delay: assert property ($rose(in_rel) |-> (!reset_pin_oe && in_rel)[*8]
      ##1 (in_rel && sample))  // see R6
      else $error("pin not sampled nine cycles after release");
   a_osc_wait_len: assert property ($fell(in_osc) |-> osc_len == 13'(OSC_CYCLES))  // see R4
      else $error("oscillator wait length wrong");
   a_ext_vector: assert property ((sample && !reset_pin_in) |=>
      (reset_vector == `RPS_VEC_NORMAL && state == st_hold))  // see R7
      else $error("external reset did not choose normal vector");
   a_clkmon_vector: assert property ((sample && reset_pin_in && cm_flag) |=>
      (reset_vector == `RPS_VEC_CLKMON && core_reset_n))  // see R8
      else $error("clock monitor vector not chosen");
   a_watchdog_vector: assert property ((sample && reset_pin_in && !cm_flag && wd_flag)
      |=> reset_vector == `RPS_VEC_WATCHDOG)  // see R9
      else $error("watchdog vector not chosen");
   a_plain_vector: assert property ((sample && reset_pin_in && !cm_flag && !wd_flag)
      |=> reset_vector == `RPS_VEC_NORMAL)  // see R10
      else $error("normal vector not chosen");
   a_cm_restart: assert property ((state == st_run && cm_event) |=> in_osc && reset_pin_oe)  // see R4
      else $error("clock failure did not start oscillator wait");
   a_masks_reset: assert property ((in_reset && !in_osc) |=> cc_reg == 2'h3)  // see R15
      else $error("masks not set during reset");
   a_irq_gate: assert property (maskable_irq_req |-> icr[`RPS_ICR_IRQ_ENABLE]
      && !cc_reg[`RPS_CC_I_MASK])  // see R13
      else $error("maskable request while disabled or masked");
   a_nmi_level: assert property ((!in_reset && !nonmaskable_irq_pin
      && $fell(cc_reg[`RPS_CC_X_MASK])) |-> nonmaskable_irq_req)  // see R19
      else $error("held nonmaskable line not recognised");
   a_mode_latch: assert property (!in_reset && $past(!in_reset) |-> $stable(op_mode))  // see R20
      else $error("mode changed outside reset");

endmodule

// ---- test/rps_far_side.sv ----
// far-side model: pulled-up reset pin and wired-OR interrupt lines
`timescale 1ns/1ns

module rps_far_side
#(
   parameter int RISE_CYCLES = 3
)
(
   input  wire logic pclk,
   input  wire logic reset_pin_out,
   input  wire logic reset_pin_oe,
   input  wire logic ext_reset_low,
   input  wire logic irq_src_low,
   input  wire logic nmi_src_low,
   output logic      reset_pin_in,
   output logic      maskable_irq_pin,
   output logic      nonmaskable_irq_pin
);
   logic pulled_low;
   int   rise_cnt = 0;

   // ------
   // reset pin
   // ------
   // open-drain wire: any low driver wins, board capacitance delays the rise
   assign pulled_low = (reset_pin_oe & ~reset_pin_out) | ext_reset_low;
   always @(posedge pclk)
      rise_cnt <= pulled_low ? RISE_CYCLES : (rise_cnt > 0 ? rise_cnt - 1 : 0);
   assign reset_pin_in = !pulled_low && rise_cnt == 0;

   // open-drain sources on pulled-up lines, low while the bench drives irq_src_low or nmi_src_low
   assign maskable_irq_pin    = ~irq_src_low;
   assign nonmaskable_irq_pin = ~nmi_src_low;
endmodule

// ---- test/rps_sequencer_tb_top.sv ----
// self-checking testbench for the reset pin sequencer
`timescale 1ns/1ns

module rps_sequencer_tb_top;
   localparam int OSC = 20;

   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        pin_in, pin_out, pin_oe, wd_to, cm_fail, irq_pin, nmi_pin;
   logic        irq_ack, pu_en, irq_req, nmi_req, m_lo, m_hi, m_sp, pd_en;
   logic        core_rst_n, ext_low, irq_src, nmi_src, en, i_m, x_m, wx;
   logic [2:0]  op_mode;
   logic [15:0] vec;
   logic [31:0] exp_rst [3] = '{32'h2, 32'h1, 32'h3};
   int          fails = 0;
   int          checked = 0;

   rps_sequencer #(.OSC_CYCLES(OSC)) uut
   (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .reset_pin_in(pin_in), .reset_pin_out(pin_out), .reset_pin_oe(pin_oe),
      .watchdog_timer_timeout(wd_to), .clock_fail(cm_fail), .maskable_irq_pin(irq_pin),
      .nonmaskable_irq_pin(nmi_pin), .maskable_irq_ack(irq_ack), .irq_pullup_en(pu_en),
      .maskable_irq_req(irq_req), .nonmaskable_irq_req(nmi_req), .mode_select_lo(m_lo),
      .mode_select_hi(m_hi), .special_mode_pin(m_sp), .mode_pulldown_en(pd_en),
      .op_mode(op_mode), .core_reset_n(core_rst_n), .reset_vector(vec)
   );

   rps_far_side far
   (
      .pclk(pclk), .reset_pin_out(pin_out), .reset_pin_oe(pin_oe), .ext_reset_low(ext_low),
      .irq_src_low(irq_src), .nmi_src_low(nmi_src), .reset_pin_in(pin_in),
      .maskable_irq_pin(irq_pin), .nonmaskable_irq_pin(nmi_pin)
   );

   // ------
   // helpers
   // ------
   task automatic check(input logic ok, input string msg);
      checked++;
      if (ok !== 1'b1)
      begin
         fails++;
         $display("Error at %0t: %s", $time, msg);
      end
   endtask

   task automatic finish_test;
      $display("checks %0d, mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // one apb transfer; waits for pready at the access edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      {psel, penable} <= 2'b00;
   endtask

   // one-cycle cause: {external low, clock fail, watchdog}
   task automatic kick(input logic [2:0] c);
      @(posedge pclk);
      {ext_low, cm_fail, wd_to} <= c;
      @(posedge pclk);
      {ext_low, cm_fail, wd_to} <= 3'h0;
   endtask

   // measure low-drive length, release length and the chosen vector
   task automatic seq(input int oe_len, input logic [15:0] v);
      int n = 0;
      int m = 0;
      @(negedge pclk);
      while (pin_oe === 1'b1 && n < 9000)
      begin
         n++;
         @(negedge pclk);
      end
      while (core_rst_n !== 1'b1 && m < 100)
      begin
         m++;
         @(negedge pclk);
      end
      check(n == oe_len && m == 9 && vec === v, "sequence timing or vector");
   endtask

   // ------
   // clock, watchdog, tests
   // ------
   initial
   begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   initial
   begin
      #300000 fails++;
      finish_test;
   end

   initial
   begin
      void'($urandom(32'h9E3F));
      {psel, penable, pwrite, paddr, pwdata, wd_to, cm_fail, irq_ack} = '0;
      {ext_low, irq_src, nmi_src} = 3'h0;
      {m_sp, m_hi, m_lo} = 3'($urandom);
      presetn = 1'b0;
      repeat (4) @(posedge pclk);
      check({op_mode, pd_en, pu_en, pin_oe, core_rst_n} === {3'h0, 4'hE}, "reset");
      presetn <= 1'b1;
      seq(OSC + 16, 16'hFFFE);
      @(posedge pclk);
      {m_sp, m_hi, m_lo} <= ~{m_sp, m_hi, m_lo};
      repeat (2) @(negedge pclk);
      check({op_mode, pd_en} === {~{m_sp, m_hi, m_lo}, 1'b0}, "mode frozen");
      kick(3'h1);
      repeat (3) @(negedge pclk);
      check({pin_oe, core_rst_n} === 2'b01, "disabled watchdog");
      apb(1'b1, 12'h00C, 32'h3);
      kick(3'h1);
      seq(16, 16'hFFFA);
      kick(3'h2);
      seq(OSC + 16, 16'hFFFC);
      kick(3'h4);
      seq(16, 16'hFFFE);
      // external low held past the sample, with a watchdog flag latched
      @(posedge pclk);
      {ext_low, wd_to} <= 2'h3;
      @(posedge pclk);
      wd_to <= 1'b0;
      repeat (40) @(negedge pclk);
      check({pin_oe, core_rst_n} === 2'b00, "held by external low");
      @(posedge pclk);
      ext_low <= 1'b0;
      repeat (6) @(negedge pclk);
      check({core_rst_n, vec} === {1'b1, 16'hFFFE}, "external vector");
      @(posedge pclk);
      presetn <= 1'b0;
      #2 check({pin_oe, core_rst_n} === 2'b10, "async entry");
      @(posedge pclk);
      presetn <= 1'b1;
      seq(OSC + 16, 16'hFFFE);
      foreach (exp_rst[i])
      begin
         apb(1'b0, 12'(4 * i), 32'h0);
         check(rd === exp_rst[i] && err === 1'b0, "register reset");
      end
      apb(1'b0, 12'h020, 32'h0);
      check(err === 1'b1 && rd === 32'h0, "unmapped access");
      // random level-mode traffic on both interrupt lines
      x_m = 1'b1;
      for (int i = 0; i < 24; i++)
      begin
         en = 1'($urandom);
         i_m = 1'($urandom);
         wx = 1'($urandom);
         x_m = x_m & wx;
         apb(1'b1, 12'h000, {30'h0, en, 1'b0});
         apb(1'b1, 12'h008, {30'h0, wx, i_m});
         @(posedge pclk);
         {irq_src, nmi_src} <= 2'($urandom);
         @(negedge pclk);
         check(irq_req === (en & ~i_m & irq_src), "level request");
         check(nmi_req === (~x_m & nmi_src), "nonmaskable request");
      end
      apb(1'b1, 12'h000, 32'h3);
      apb(1'b1, 12'h008, 32'h0);
      @(posedge pclk);
      irq_src <= 1'b0;
      @(posedge pclk);
      irq_src <= 1'b1;
      repeat (2) @(negedge pclk);
      check(irq_req === 1'b1, "edge pending");
      @(posedge pclk);
      irq_ack <= 1'b1;
      @(posedge pclk);
      irq_ack <= 1'b0;
      @(negedge pclk);
      check(irq_req === 1'b0, "edge acknowledged");
      apb(1'b1, 12'h004, 32'h0);
      @(negedge pclk);
      check(pu_en === 1'b0, "pull-up off");
      // status: vector, latched mode, pin levels, no pending edge or flags
      apb(1'b0, 12'h010, 32'h0);
      check(rd === {16'hFFFE, 8'h0, m_sp, m_hi, m_lo, 1'b0, ~nmi_src, ~irq_src, 2'h0},
            "status readback");
      finish_test;
   end
endmodule
